// file: design/oh_fifo.sv
`timescale 1ns/1ps
module oh_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } fifo_state_t;

    fifo_state_t      st;
    fifo_state_t      next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             do_push;
    logic             do_pop;

    assign in_ready  = (st.count != (AW+1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = mem[st.rd_ptr];
    assign do_push   = in_valid && in_ready;
    assign do_pop    = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (do_pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; only the pointers and the count say what is valid
    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem[st.wr_ptr] <= in_data;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (!resetn)
        st.count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule : oh_fifo

// file: design/oh_insert_pkg.sv
package oh_insert_pkg;

    // ==========================================================
    // Framing modes
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_T3   = 2'b01,
        MODE_G751 = 2'b10,
        MODE_G832 = 2'b11
    } frame_mode_t;

    // ==========================================================
    // Sequence lengths in overhead bits
    localparam logic [5:0] T3_OH_BITS   = 6'h38;  // X, P, M, F and C bits of a frame
    localparam logic [5:0] G751_OH_BITS = 6'h0c;  // Alignment word, alarm and national bits
    localparam logic [5:0] G832_OH_BITS = 6'h38;  // Seven overhead bytes

    // ==========================================================
    // Port clock timing
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         OHCLK_HALF_NS   = 80;
    localparam logic [3:0] OHCLK_HALF_CYC  = 4'(OHCLK_HALF_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Buffer shape and reset values
    localparam int         FIFO_WIDTH      = 2;
    localparam int         FIFO_DEPTH      = 16;
    localparam logic [5:0] POS_RESET       = 6'h00;
    localparam logic [3:0] DIV_RESET       = 4'h0;

    function automatic logic [5:0] seq_len(input frame_mode_t mode);
        unique case (mode)
            MODE_T3:   seq_len = T3_OH_BITS;
            MODE_G751: seq_len = G751_OH_BITS;
            MODE_G832: seq_len = G832_OH_BITS;
            MODE_OFF:  seq_len = 6'h01;
        endcase
    endfunction : seq_len

endpackage : oh_insert_pkg

// file: design/tx_overhead_insert_port.sv
`timescale 1ns/1ps
// Contract
// - Inputs used only in DS3/E3 framing modes
// - Enabled positions take sampled insert data
// - T3 sequence: X, P, M, F, C bits
// - G.751 sequence: alignment, alarm, national bits
// - G.832 sequence: seven overhead bytes
// - Frame-start marks sequence; source aligns to it
// - Data and enable sampled on clock fall
// - Separate polarity inversion for data, enable
// - Marker updates on fall; source changes on rise
// - Marker flags first overhead bit of sequence
// - Sequence begins on marker's falling edge
// - Port clock slow, toggles only when needed
module tx_overhead_insert_port
    import oh_insert_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Configuration
    input  wire frame_mode_t framing_mode,
    input  wire logic        invert_data,
    input  wire logic        invert_enable,
    // Overhead port pins
    input  wire logic        overhead_insert_data,
    input  wire logic        overhead_insert_enable,
    output logic             overhead_port_clock,
    output logic             overhead_frame_start_out,
    // Framer side: generated overhead bit in, merged bit out
    input  wire logic        gen_valid,
    input  wire logic        gen_bit,
    output logic             merged_valid,
    output logic             merged_bit
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]  sync_d1;
        logic [1:0]  sync_d2;
        logic [3:0]  div_cnt;
        logic        port_clk;
        logic [5:0]  pos;
        logic        primed;
        logic        sof;
        logic        push_valid;
        logic [1:0]  push_word;
        frame_mode_t last_mode;
        logic        out_valid;
        logic        out_bit;
    } port_state_t;

    port_state_t st;
    port_state_t next_st;

    logic        active;
    logic        advance;
    logic        fall;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [1:0]  fifo_out_data;
    logic        fifo_pop;
    logic        samp_data;
    logic        samp_en;
    logic [5:0]  pos_next;

    // ==========================================================
    // Combinational control
    assign active    = (framing_mode != MODE_OFF) && (framing_mode == st.last_mode);
    assign samp_data = st.sync_d2[1] ^ invert_data;
    assign samp_en   = st.sync_d2[0] ^ invert_enable;
    // Besides leaving an active mode, only a sample blocked by a full buffer stops the divider; a normal push costs no cycle
    assign advance   = active && !(st.push_valid && !fifo_in_ready);
    assign fall      = advance && st.port_clk && (st.div_cnt == OHCLK_HALF_CYC - 4'h1);
    assign pos_next  = (st.pos == seq_len(framing_mode) - 6'h01) ? POS_RESET
                                                                 : st.pos + 6'h01;
    assign fifo_pop  = gen_valid && active && fifo_out_valid;

    always_comb begin
        next_st           = st;
        next_st.sync_d1   = {overhead_insert_data, overhead_insert_enable};
        next_st.sync_d2   = st.sync_d1;
        next_st.last_mode = framing_mode;
        if (st.push_valid && fifo_in_ready) begin
            next_st.push_valid = 1'b0;
        end
        if (!active) begin
            // Idle or mode just changed: park clock low and restart the sequence
            next_st.div_cnt    = DIV_RESET;
            next_st.port_clk   = 1'b0;
            next_st.pos        = seq_len(framing_mode) - 6'h01;
            next_st.primed     = 1'b0;
            next_st.sof        = 1'b0;
            next_st.push_valid = 1'b0;
        end else if (advance) begin
            // A sample waiting on a full buffer freezes the port clock, so none is dropped
            if (st.div_cnt == OHCLK_HALF_CYC - 4'h1) begin
                next_st.div_cnt  = DIV_RESET;
                next_st.port_clk = !st.port_clk;
            end else begin
                next_st.div_cnt = st.div_cnt + 4'h1;
            end
            if (fall) begin
                // Sample belongs to the position announced at the previous fall
                next_st.push_valid = st.primed;
                next_st.push_word  = {samp_data, samp_en};
                next_st.primed     = 1'b1;
                next_st.pos        = pos_next;
                next_st.sof        = (pos_next == POS_RESET);
            end
        end
        next_st.out_valid = gen_valid;
        if (fifo_pop && fifo_out_data[0]) begin
            next_st.out_bit = fifo_out_data[1];
        end else begin
            next_st.out_bit = gen_bit;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st           <= '0;
            st.pos       <= POS_RESET;
            st.div_cnt   <= DIV_RESET;
            st.last_mode <= MODE_OFF;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Sample buffer
    oh_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .in_valid  (st.push_valid),
        .in_data   (st.push_word),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_pop)
    );

    assign overhead_port_clock      = st.port_clk;
    assign overhead_frame_start_out = st.sof;
    assign merged_valid             = st.out_valid;
    assign merged_bit               = st.out_bit;

    // ==========================================================
    // Checks
    a_idle_clock_low: assert property (@(posedge clk_sys) disable iff (!resetn)
        (framing_mode == MODE_OFF) |=> !overhead_port_clock && !st.push_valid)
        else $error("port active while framing is off");

    a_sof_on_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(overhead_frame_start_out) |-> $fell(overhead_port_clock))
        else $error("frame start changed away from a falling clock");

    a_sof_first_pos: assert property (@(posedge clk_sys) disable iff (!resetn)
        overhead_frame_start_out |-> st.pos == POS_RESET)
        else $error("frame start not on first overhead bit");

    a_push_after_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(st.push_valid) |-> $fell(st.port_clk))
        else $error("sample taken away from a falling clock");

    a_push_polarity: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(st.push_valid) |-> st.push_word == {$past(samp_data), $past(samp_en)})
        else $error("sample does not follow polarity setting");

    a_merge_insert: assert property (@(posedge clk_sys) disable iff (!resetn)
        fifo_pop && fifo_out_data[0] |=> merged_bit == $past(fifo_out_data[1]))
        else $error("enabled position lost insert data");

    a_merge_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
        gen_valid && !(fifo_pop && fifo_out_data[0]) |=> merged_bit == $past(gen_bit))
        else $error("disabled position altered generated bit");

    a_clock_half_period: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(overhead_port_clock) && active |=> overhead_port_clock [*7])
        else $error("port clock high phase too short");

    a_seq_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
        fall && st.pos == seq_len(framing_mode) - 6'h01 |=> st.sof && st.pos == POS_RESET)
        else $error("sequence did not restart at marker");

    a_clock_low_phase: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(overhead_port_clock) && active |=> !overhead_port_clock [*7])
        else $error("port clock low phase too short");

    a_stall_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
        active && st.push_valid && !fifo_in_ready |=> st.push_valid && $stable(st.port_clk))
        else $error("blocked sample lost or port clock moved");

    a_pos_range: assert property (@(posedge clk_sys)
        disable iff (!resetn) active |-> st.pos < seq_len(framing_mode))
        else $error("overhead position beyond sequence length");

    a_merged_valid: assert property (@(posedge clk_sys) disable iff (!resetn)
        1'b1 |=> merged_valid == $past(gen_valid))
        else $error("merged strobe not one cycle after framer strobe");

    a_sof_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(overhead_frame_start_out) && active |=> overhead_frame_start_out [*7])
        else $error("frame start dropped inside its port period");

    // ==========================================================
    // Coverage
    c_sof_seen: cover property (@(posedge clk_sys) disable iff (!resetn)
        $rose(overhead_frame_start_out));
    c_insert_bit: cover property (@(posedge clk_sys) disable iff (!resetn)
        fifo_pop && fifo_out_data[0]);
    c_stall_full: cover property (@(posedge clk_sys) disable iff (!resetn)
        active && !fifo_in_ready);
    c_keep_bit: cover property (@(posedge clk_sys) disable iff (!resetn)
        fifo_pop && !fifo_out_data[0]);
    c_short_wrap: cover property (@(posedge clk_sys) disable iff (!resetn)
        $rose(overhead_frame_start_out) && framing_mode == MODE_G751);

endmodule : tx_overhead_insert_port

// file: test/oh_source.sv
`timescale 1ns/1ps
// ==========================================================
// Overhead source: realigns on the marker and steps on each port-clock rise
module oh_source (
    // Port pins
    input  wire logic        overhead_port_clock,
    input  wire logic        overhead_frame_start_out,
    output logic             overhead_insert_data,
    output logic             overhead_insert_enable,
    // Pattern and polarity
    input  wire logic        invert_data,
    input  wire logic        invert_enable,
    input  wire logic [63:0] pat_data,
    input  wire logic [63:0] pat_enable
);
    logic [5:0] pos = 6'h00;

    // Pins only move on the rise, so they are settled long before the fall
    always @(posedge overhead_port_clock) begin
        pos <= overhead_frame_start_out ? 6'h00 : pos + 6'h01;
    end

    assign overhead_insert_data   = pat_data[pos] ^ invert_data;
    assign overhead_insert_enable = pat_enable[pos] ^ invert_enable;
endmodule : oh_source

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
    import oh_insert_pkg::*;
    // ==========================================================
    // Signals and bookkeeping
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    frame_mode_t mode = MODE_OFF;
    logic        inv_d = 1'b0;
    logic        inv_e = 1'b0;
    logic        gen_valid = 1'b0;
    logic        gen_bit = 1'b0;
    logic        d_pin, e_pin, pclk, sof, mv, mb;
    logic        pclk_q = 1'b0;
    logic [63:0] pd = 64'h0;
    logic [63:0] pe = '1;
    int          seed = 76365;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          falls = 0;
    int          last_fall = 0;
    int          mpos = -1;
    logic [1:0]  model_q[$];

    always #5 clk_sys = ~clk_sys;

    tx_overhead_insert_port dut (
        .clk_sys(clk_sys), .resetn(resetn), .framing_mode(mode),
        .invert_data(inv_d), .invert_enable(inv_e),
        .overhead_insert_data(d_pin), .overhead_insert_enable(e_pin),
        .overhead_port_clock(pclk), .overhead_frame_start_out(sof),
        .gen_valid(gen_valid), .gen_bit(gen_bit),
        .merged_valid(mv), .merged_bit(mb));

    oh_source src (
        .overhead_port_clock(pclk), .overhead_frame_start_out(sof),
        .overhead_insert_data(d_pin), .overhead_insert_enable(e_pin),
        .invert_data(inv_d), .invert_enable(inv_e),
        .pat_data(pd), .pat_enable(pe));

    // ==========================================================
    // Port-clock fall tracker, reference model and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        pclk_q <= pclk;
        if (!resetn) begin
            mpos <= -1;
            model_q.delete();
        end else if (pclk_q === 1'b1 && pclk === 1'b0) begin
            falls <= falls + 1;
            last_fall <= cyc;
            // First fall after start only announces position 0
            if (mpos >= 0) model_q.push_back({pd[mpos], pe[mpos]});
            mpos <= (mpos + 1) % seq_bits(mode);
        end
        if (cyc > 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ==========================================================
    // Tasks
    task automatic close_out();
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Overhead bits per sequence for each framing mode
    function automatic int seq_bits(input frame_mode_t m);
        case (m)
            MODE_T3:   return 56;
            MODE_G751: return 12;
            MODE_G832: return 56;
            default:   return 1;
        endcase
    endfunction : seq_bits

    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic wait_fall();
        int k;
        k = falls;
        for (int i = 0; i < 400 && falls == k; i++) tick();
    endtask : wait_fall

    // Held high across back-to-back pops so the strobe never toggles twice in a step
    task automatic pop(input logic last);
        logic       g;
        logic [1:0] w;
        g = 1'($random(seed));
        w = 2'b00;
        if (model_q.size() > 0) w = model_q.pop_front();
        gen_valid = 1'b1;
        gen_bit = g;
        tick();
        if (last) gen_valid = 1'b0;
        check(8'(mv), 8'h01);
        check(8'(mb), 8'(w[0] ? w[1] : g));
    endtask : pop

    task automatic start(input frame_mode_t m, input logic id, input logic ie);
        resetn = 1'b0;
        mode = m;
        inv_d = id;
        inv_e = ie;
        pd = {$random(seed), $random(seed)};
        pe = {$random(seed), $random(seed)};
        tick();
        tick();
        check(8'({pclk, sof, mv}), 8'h00);
        resetn = 1'b1;
        for (int i = 0; i < 3 && sof !== 1'b1; i++) wait_fall();
        check(8'(sof), 8'h01);
    endtask : start

    task automatic run(input frame_mode_t m, input logic id, input logic ie,
                       input int len, input int n);
        int lf;
        start(m, id, ie);
        for (int p = 0; p < n; p++) begin
            lf = last_fall;
            wait_fall();
            check(8'(last_fall - lf), 8'h10);
            check(8'(sof), 8'(((p + 1) % len) == 0));
            tick();
            pop(1'b1);
        end
        $display("Test mode %0d done", m);
    endtask : run

    // ==========================================================
    // Main sequence
    initial begin
        tick();
        tick();
        resetn = 1'b1;
        repeat (50) tick();
        check(8'({pclk, sof}), 8'h00);
        for (int i = 0; i < 4; i++) pop(i == 3);
        $display("Test mode off done");
        run(MODE_T3, 1'b0, 1'b0, 56, 60);
        run(MODE_G751, 1'b1, 1'b0, 12, 28);
        run(MODE_G832, 1'b0, 1'b1, 56, 60);
        // Stall the framer: buffer fills, port clock must freeze, then drain in order
        start(MODE_T3, 1'b1, 1'b1);
        repeat (400) tick();
        check(8'(cyc - last_fall > 40), 8'h01);
        for (int p = 0; p < 16; p++) pop(p == 15);
        $display("Test buffer full done");
        close_out();
    end
endmodule : tb
